// ---- rtl/mlat_defines.vh ----
// Constants of the address learning and aging table.
// Included by the table module; definitions only.
`ifndef MLAT_DEFINES_VH
`define MLAT_DEFINES_VH

// ==========================================================
// Register byte offsets
`define MLAT_REG_CTRL       8'h00
`define MLAT_REG_AGE_TIME   8'h04
`define MLAT_REG_LEARN_MODE 8'h08
`define MLAT_REG_KEY_VID    8'h0C
`define MLAT_REG_KEY_MAC_LO 8'h10
`define MLAT_REG_KEY_MAC_HI 8'h14
`define MLAT_REG_KEY_PORTS  8'h18
`define MLAT_REG_CMD        8'h1C
`define MLAT_REG_STATUS     8'h20
`define MLAT_REG_RES_VID    8'h24
`define MLAT_REG_RES_MAC_LO 8'h28
`define MLAT_REG_RES_MAC_HI 8'h2C
`define MLAT_REG_RES_PORTS  8'h30

// ==========================================================
// Fields and reset values
`define MLAT_CTRL_AGE_EN_BIT 0
`define MLAT_STAT_BUSY_BIT   0
`define MLAT_STAT_EOT_BIT    1
`define MLAT_STAT_STATIC_BIT 2
`define MLAT_STAT_ERR_BIT    3
`define MLAT_AGE_MIN         24'h00000A
`define MLAT_AGE_MAX         24'h989680
`define MLAT_AGE_DEFAULT     24'h00012C
`define MLAT_STATIC_MAX      7'h40
`define MLAT_TABLE_DEPTH     8192

// ==========================================================
// Learning modes and management commands
`define MLAT_MODE_AUTO     2'h0
`define MLAT_MODE_DISABLED 2'h1
`define MLAT_MODE_SECURE   2'h2
`define MLAT_CMD_ADD       3'h1
`define MLAT_CMD_DELETE    3'h2
`define MLAT_CMD_READ_NEXT 3'h3
`define MLAT_CMD_FLUSH     3'h4

// ==========================================================
// Timing
`define MLAT_CLK_PERIOD_NS 10
`define MLAT_SECOND_NS     1000000000

`endif

// ---- rtl/mlat_table.v ----
// Address learning and aging table with AXI4-Lite management registers.
// Assumes one clock, a forwarding pipeline that takes rsp_valid pulses
// without back-pressure, and synchronous inputs.
//
// Overview of operation
// - Egress ports of a frame come from looking up its destination_hw_address.
// - Static entries from management and learned dynamic entries share the table.
// - On an auto port, a frame's source_hw_address creates or refreshes a dynamic entry for its port.
// - A dynamic entry is removed once its address has not been seen for the aging time.
// - Aging time is 10 to 10000000 whole seconds, 300 after reset.
// - A control bit switches aging off, and then no dynamic entry ages out.
// - An auto port adds a dynamic entry for an unknown source address at once.
// - A disabled port neither creates nor refreshes dynamic entries.
// - A secure port passes only frames whose source matches a static entry.
// - An outside controller may lock a port's mode, and user writes then are ignored.
// - At most 64 static entries exist, enumerated by VLAN ID then address.
// - A static entry is keyed by VLAN ID and address and carries a port bitmap.
// - The table holds up to 8192 entries, enumerable by VLAN ID then address.
// - Flush deletes all dynamic entries and leaves static ones.
// - A table read returns the exact key or the next larger, else end-of-table.
// - A read result gives type, VLAN ID, address and port membership.
//
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`include "mlat_defines.vh"

module mlat_table #(
   parameter NPORT  = 10,
   parameter DEPTH  = `MLAT_TABLE_DEPTH,
   parameter CLK_HZ = `MLAT_SECOND_NS / `MLAT_CLK_PERIOD_NS
) (
   // Clock and reset
   input  wire                     clock,
   input  wire                     reset,
   // Frame query from the forwarding pipeline
   input  wire                     req_valid,
   output reg                      req_ready_r,
   input  wire [11:0]              req_vid,
   input  wire [47:0]              destination_hw_address,
   input  wire [47:0]              source_hw_address,
   input  wire [3:0]               req_port,
   // Forwarding decision
   output reg                      rsp_valid_r,
   output reg  [NPORT-1:0]         rsp_ports_r,
   output reg                      rsp_drop_r,
   output reg                      rsp_hit_r,
   // Mode lock from another controlling function
   input  wire [NPORT-1:0]         lock_mask,
   input  wire [2*NPORT-1:0]       lock_mode,
   // AXI4-Lite slave
   input  wire [7:0]               s_axi_awaddr,
   input  wire                     s_axi_awvalid,
   output reg                      s_axi_awready_r,
   input  wire [31:0]              s_axi_wdata,
   input  wire [3:0]               s_axi_wstrb,
   input  wire                     s_axi_wvalid,
   output reg                      s_axi_wready_r,
   output reg  [1:0]               s_axi_bresp_r,
   output reg                      s_axi_bvalid_r,
   input  wire                     s_axi_bready,
   input  wire [7:0]               s_axi_araddr,
   input  wire                     s_axi_arvalid,
   output reg                      s_axi_arready_r,
   output reg  [31:0]              s_axi_rdata_r,
   output reg  [1:0]               s_axi_rresp_r,
   output reg                      s_axi_rvalid_r,
   input  wire                     s_axi_rready
);
   localparam AW = $clog2(DEPTH);
   localparam ST_IDLE = 2'h0;
   localparam ST_SCAN = 2'h1;
   localparam ST_DONE = 2'h2;
   localparam OP_FRAME = 3'h0;
   localparam OP_AGE   = 3'h5;

   // ==========================================================
   // Functions
   function [1:0] mode_of;
      input [2*NPORT-1:0] modes;
      input [3:0]         p;
      begin
         mode_of = modes[2*p +: 2];
      end
   endfunction

   function [NPORT-1:0] port_bit;
      input [3:0] p;
      begin
         port_bit = {{(NPORT-1){1'b0}}, 1'b1} << p;
      end
   endfunction

   // ==========================================================
   // Storage and state
   reg  [DEPTH-1:0]   vld_r;
   reg  [DEPTH-1:0]   stat_r;
   reg  [DEPTH-1:0]   act_r;
   reg  [11:0]        vid_r [0:DEPTH-1];
   reg  [47:0]        mac_r [0:DEPTH-1];
   reg  [NPORT-1:0]   mem_r [0:DEPTH-1];
   reg  [1:0]         state_r;
   reg  [2:0]         op_r;
   reg  [AW-1:0]      idx_r;
   reg  [11:0]        k_vid_r;
   reg  [47:0]        k_mac_r;
   reg  [47:0]        k_dst_r;
   reg  [NPORT-1:0]   k_ports_r;
   reg  [3:0]         k_port_r;
   reg                dst_hit_r;
   reg  [NPORT-1:0]   dst_ports_r;
   reg                src_hit_r;
   reg                src_stat_r;
   reg  [AW-1:0]      src_idx_r;
   reg                free_ok_r;
   reg  [AW-1:0]      free_idx_r;
   reg  [6:0]         nstat_r;
   reg                best_ok_r;
   reg  [59:0]        best_key_r;
   reg  [AW-1:0]      best_idx_r;
   reg                age_en_r;
   reg  [23:0]        age_time_r;
   reg  [2*NPORT-1:0] mode_r;
   reg  [11:0]        key_vid_r;
   reg  [47:0]        key_mac_r;
   reg  [NPORT-1:0]   key_ports_r;
   reg  [2:0]         cmd_r;
   reg                cmd_pend_r;
   reg                eot_r;
   reg                res_stat_r;
   reg                err_r;
   reg  [11:0]        res_vid_r;
   reg  [47:0]        res_mac_r;
   reg  [NPORT-1:0]   res_ports_r;
   reg  [31:0]        sec_cnt_r;
   reg  [23:0]        age_cnt_r;
   reg                age_pend_r;
   reg                aw_got_r;
   reg                w_got_r;
   reg  [7:0]         waddr_r;
   reg  [31:0]        wdata_r;
   integer            i;

   wire [59:0]        e_key   = {vid_r[idx_r], mac_r[idx_r]};
   wire [59:0]        k_key   = {k_vid_r, k_mac_r};
   wire               e_vld   = vld_r[idx_r];
   wire               e_stat  = stat_r[idx_r];
   wire               last    = (idx_r == DEPTH - 1);
   wire [2*NPORT-1:0] eff_mode = (mode_r & ~lock_bits(lock_mask))
                                 | (lock_mode & lock_bits(lock_mask));
   wire [1:0]         in_mode = mode_of(eff_mode, k_port_r);
   wire               tick    = (sec_cnt_r == CLK_HZ - 1);
   wire               wr_go   = aw_got_r && w_got_r && !s_axi_bvalid_r;
   wire               busy    = cmd_pend_r || (state_r != ST_IDLE && op_r != OP_FRAME);
   wire               age_go  = (state_r == ST_IDLE) && !(req_valid && req_ready_r)
                                && !cmd_pend_r && age_pend_r;
   wire [23:0]        wr_age  = (wdata_r[23:0] < `MLAT_AGE_MIN) ? `MLAT_AGE_MIN :
                                (wdata_r[23:0] > `MLAT_AGE_MAX) ? `MLAT_AGE_MAX :
                                wdata_r[23:0];

   // ==========================================================
   // One-second tick and aging period
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         sec_cnt_r  <= 32'h00000000;
         age_cnt_r  <= 24'h000000;
         age_pend_r <= 1'b0;
      end else begin
         sec_cnt_r <= tick ? 32'h00000000 : sec_cnt_r + 32'h00000001;
         if (!age_en_r) begin
            age_cnt_r <= 24'h000000;
         end else if (tick) begin
            age_cnt_r <= (age_cnt_r >= age_time_r - 24'h000001) ? 24'h000000
                         : age_cnt_r + 24'h000001;
         end
         // A new period end wins over the start that clears the request
         age_pend_r <= (age_pend_r && !age_go)
                       || (age_en_r && tick && age_cnt_r >= age_time_r - 24'h000001);
      end
   end

   // ==========================================================
   // Table engine
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         vld_r       <= {DEPTH{1'b0}};
         stat_r      <= {DEPTH{1'b0}};
         act_r       <= {DEPTH{1'b0}};
         state_r     <= ST_IDLE;
         op_r        <= OP_FRAME;
         idx_r       <= {AW{1'b0}};
         k_vid_r     <= 12'h000;
         k_mac_r     <= 48'h000000000000;
         k_dst_r     <= 48'h000000000000;
         k_ports_r   <= {NPORT{1'b0}};
         k_port_r    <= 4'h0;
         dst_hit_r   <= 1'b0;
         dst_ports_r <= {NPORT{1'b0}};
         src_hit_r   <= 1'b0;
         src_stat_r  <= 1'b0;
         src_idx_r   <= {AW{1'b0}};
         free_ok_r   <= 1'b0;
         free_idx_r  <= {AW{1'b0}};
         nstat_r     <= 7'h00;
         best_ok_r   <= 1'b0;
         best_key_r  <= 60'h000000000000000;
         best_idx_r  <= {AW{1'b0}};
         req_ready_r <= 1'b0;
         rsp_valid_r <= 1'b0;
         rsp_ports_r <= {NPORT{1'b0}};
         rsp_drop_r  <= 1'b0;
         rsp_hit_r   <= 1'b0;
         eot_r       <= 1'b0;
         res_stat_r  <= 1'b0;
         err_r       <= 1'b0;
         res_vid_r   <= 12'h000;
         res_mac_r   <= 48'h000000000000;
         res_ports_r <= {NPORT{1'b0}};
      end else begin
         rsp_valid_r <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               idx_r      <= {AW{1'b0}};
               dst_hit_r  <= 1'b0;
               src_hit_r  <= 1'b0;
               free_ok_r  <= 1'b0;
               nstat_r    <= 7'h00;
               best_ok_r  <= 1'b0;
               if (req_valid && req_ready_r) begin
                  req_ready_r <= 1'b0;
                  op_r        <= OP_FRAME;
                  k_vid_r     <= req_vid;
                  k_mac_r     <= source_hw_address;
                  k_dst_r     <= destination_hw_address;
                  k_port_r    <= req_port;
                  state_r     <= ST_SCAN;
               end else if (cmd_pend_r) begin
                  req_ready_r <= 1'b0;
                  op_r        <= cmd_r;
                  k_vid_r     <= key_vid_r;
                  k_mac_r     <= key_mac_r;
                  k_ports_r   <= key_ports_r;
                  state_r     <= ST_SCAN;
               end else if (age_pend_r) begin
                  req_ready_r <= 1'b0;
                  op_r        <= OP_AGE;
                  state_r     <= ST_SCAN;
               end else begin
                  req_ready_r <= 1'b1;
               end
            end
            ST_SCAN: begin
               idx_r <= idx_r + {{(AW-1){1'b0}}, 1'b1};
               if (last) begin
                  state_r <= ST_DONE;
               end
               if (!e_vld && !free_ok_r) begin
                  free_ok_r  <= 1'b1;
                  free_idx_r <= idx_r;
               end
               if (e_vld && e_stat) begin
                  nstat_r <= nstat_r + 7'h01;
               end
               if (e_vld && {vid_r[idx_r], mac_r[idx_r]} == {k_vid_r, k_dst_r}) begin
                  dst_hit_r   <= 1'b1;
                  dst_ports_r <= mem_r[idx_r];
               end
               if (e_vld && e_key == k_key) begin
                  src_hit_r  <= 1'b1;
                  src_stat_r <= e_stat;
                  src_idx_r  <= idx_r;
               end
               if (e_vld && e_key >= k_key && (!best_ok_r || e_key < best_key_r)) begin
                  best_ok_r  <= 1'b1;
                  best_key_r <= e_key;
                  best_idx_r <= idx_r;
               end
               if (op_r == `MLAT_CMD_FLUSH && e_vld && !e_stat) begin
                  vld_r[idx_r] <= 1'b0;
               end
               if (op_r == `MLAT_CMD_DELETE && e_vld && e_stat && e_key == k_key) begin
                  vld_r[idx_r]  <= 1'b0;
                  stat_r[idx_r] <= 1'b0;
               end
               if (op_r == OP_AGE && e_vld && !e_stat) begin
                  vld_r[idx_r] <= act_r[idx_r];
                  act_r[idx_r] <= 1'b0;
               end
            end
            ST_DONE: begin
               state_r <= ST_IDLE;
               case (op_r)
                  OP_FRAME: begin
                     rsp_valid_r <= 1'b1;
                     rsp_hit_r   <= dst_hit_r;
                     rsp_drop_r  <= (in_mode == `MLAT_MODE_SECURE)
                                    && !(src_hit_r && src_stat_r);
                     rsp_ports_r <= ((in_mode == `MLAT_MODE_SECURE) && !(src_hit_r && src_stat_r))
                                    ? {NPORT{1'b0}}
                                    : (dst_hit_r ? dst_ports_r : {NPORT{1'b1}})
                                      & ~port_bit(k_port_r);
                     if (in_mode == `MLAT_MODE_AUTO) begin
                        if (src_hit_r && !src_stat_r) begin
                           act_r[src_idx_r] <= 1'b1;
                           mem_r[src_idx_r] <= port_bit(k_port_r);
                        end else if (!src_hit_r && free_ok_r) begin
                           vld_r[free_idx_r]  <= 1'b1;
                           stat_r[free_idx_r] <= 1'b0;
                           act_r[free_idx_r]  <= 1'b1;
                           vid_r[free_idx_r]  <= k_vid_r;
                           mac_r[free_idx_r]  <= k_mac_r;
                           mem_r[free_idx_r]  <= port_bit(k_port_r);
                        end
                     end
                  end
                  `MLAT_CMD_ADD: begin
                     if (src_hit_r && (src_stat_r || nstat_r < `MLAT_STATIC_MAX)) begin
                        err_r              <= 1'b0;
                        stat_r[src_idx_r]  <= 1'b1;
                        mem_r[src_idx_r]   <= k_ports_r;
                     end else if (!src_hit_r && free_ok_r && nstat_r < `MLAT_STATIC_MAX) begin
                        err_r              <= 1'b0;
                        vld_r[free_idx_r]  <= 1'b1;
                        stat_r[free_idx_r] <= 1'b1;
                        act_r[free_idx_r]  <= 1'b0;
                        vid_r[free_idx_r]  <= k_vid_r;
                        mac_r[free_idx_r]  <= k_mac_r;
                        mem_r[free_idx_r]  <= k_ports_r;
                     end else begin
                        err_r <= 1'b1;
                     end
                  end
                  `MLAT_CMD_READ_NEXT: begin
                     eot_r       <= !best_ok_r;
                     res_stat_r  <= best_ok_r && stat_r[best_idx_r];
                     res_vid_r   <= best_ok_r ? vid_r[best_idx_r] : 12'h000;
                     res_mac_r   <= best_ok_r ? mac_r[best_idx_r] : 48'h000000000000;
                     res_ports_r <= best_ok_r ? mem_r[best_idx_r] : {NPORT{1'b0}};
                  end
                  default: begin
                     err_r <= 1'b0;
                  end
               endcase
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // AXI4-Lite register slave
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         s_axi_awready_r <= 1'b1;
         s_axi_wready_r  <= 1'b1;
         s_axi_bvalid_r  <= 1'b0;
         s_axi_bresp_r   <= 2'h0;
         s_axi_arready_r <= 1'b1;
         s_axi_rvalid_r  <= 1'b0;
         s_axi_rresp_r   <= 2'h0;
         s_axi_rdata_r   <= 32'h00000000;
         aw_got_r        <= 1'b0;
         w_got_r         <= 1'b0;
         waddr_r         <= 8'h00;
         wdata_r         <= 32'h00000000;
         age_en_r        <= 1'b1;
         age_time_r      <= `MLAT_AGE_DEFAULT;
         mode_r          <= {(2*NPORT){1'b0}};
         key_vid_r       <= 12'h000;
         key_mac_r       <= 48'h000000000000;
         key_ports_r     <= {NPORT{1'b0}};
         cmd_r           <= 3'h0;
         cmd_pend_r      <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready_r) begin
            aw_got_r        <= 1'b1;
            waddr_r         <= s_axi_awaddr;
            s_axi_awready_r <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready_r) begin
            w_got_r        <= 1'b1;
            wdata_r        <= s_axi_wdata;
            s_axi_wready_r <= 1'b0;
         end
         if (state_r == ST_IDLE && !(req_valid && req_ready_r)) begin
            cmd_pend_r <= 1'b0;
         end
         if (wr_go) begin
            s_axi_bvalid_r <= 1'b1;
            s_axi_bresp_r  <= 2'h0;
            case ({waddr_r[7:2], 2'b00})
               `MLAT_REG_CTRL:       age_en_r  <= wdata_r[`MLAT_CTRL_AGE_EN_BIT];
               `MLAT_REG_AGE_TIME:   age_time_r <= wr_age;
               `MLAT_REG_LEARN_MODE: begin
                  for (i = 0; i < NPORT; i = i + 1) begin
                     if (!lock_mask[i]) begin
                        mode_r[2*i +: 2] <= wdata_r[2*i +: 2];
                     end
                  end
               end
               `MLAT_REG_KEY_VID:    key_vid_r <= wdata_r[11:0];
               `MLAT_REG_KEY_MAC_LO: key_mac_r[31:0] <= wdata_r;
               `MLAT_REG_KEY_MAC_HI: key_mac_r[47:32] <= wdata_r[15:0];
               `MLAT_REG_KEY_PORTS:  key_ports_r <= wdata_r[NPORT-1:0];
               `MLAT_REG_CMD: begin
                  if (!busy && wdata_r[2:0] >= `MLAT_CMD_ADD
                      && wdata_r[2:0] <= `MLAT_CMD_FLUSH) begin
                     cmd_r      <= wdata_r[2:0];
                     cmd_pend_r <= 1'b1;
                  end
               end
               `MLAT_REG_STATUS, `MLAT_REG_RES_VID, `MLAT_REG_RES_MAC_LO,
               `MLAT_REG_RES_MAC_HI, `MLAT_REG_RES_PORTS: s_axi_bresp_r <= 2'h0;
               default:              s_axi_bresp_r <= 2'h3;
            endcase
         end
         if (s_axi_bvalid_r && s_axi_bready) begin
            s_axi_bvalid_r  <= 1'b0;
            aw_got_r        <= 1'b0;
            w_got_r         <= 1'b0;
            s_axi_awready_r <= 1'b1;
            s_axi_wready_r  <= 1'b1;
         end
         if (s_axi_arvalid && s_axi_arready_r) begin
            s_axi_arready_r <= 1'b0;
            s_axi_rvalid_r  <= 1'b1;
            s_axi_rresp_r   <= 2'h0;
            case ({s_axi_araddr[7:2], 2'b00})
               `MLAT_REG_CTRL:       s_axi_rdata_r <= {31'h00000000, age_en_r};
               `MLAT_REG_AGE_TIME:   s_axi_rdata_r <= {8'h00, age_time_r};
               `MLAT_REG_LEARN_MODE: s_axi_rdata_r <= {{(32-2*NPORT){1'b0}}, eff_mode};
               `MLAT_REG_KEY_VID:    s_axi_rdata_r <= {20'h00000, key_vid_r};
               `MLAT_REG_KEY_MAC_LO: s_axi_rdata_r <= key_mac_r[31:0];
               `MLAT_REG_KEY_MAC_HI: s_axi_rdata_r <= {16'h0000, key_mac_r[47:32]};
               `MLAT_REG_KEY_PORTS:  s_axi_rdata_r <= {{(32-NPORT){1'b0}}, key_ports_r};
               `MLAT_REG_CMD:        s_axi_rdata_r <= {29'h00000000, cmd_r};
               `MLAT_REG_STATUS:     s_axi_rdata_r <= {28'h0000000, err_r, res_stat_r,
                                                       eot_r, busy};
               `MLAT_REG_RES_VID:    s_axi_rdata_r <= {20'h00000, res_vid_r};
               `MLAT_REG_RES_MAC_LO: s_axi_rdata_r <= res_mac_r[31:0];
               `MLAT_REG_RES_MAC_HI: s_axi_rdata_r <= {16'h0000, res_mac_r[47:32]};
               `MLAT_REG_RES_PORTS:  s_axi_rdata_r <= {{(32-NPORT){1'b0}}, res_ports_r};
               default: begin
                  s_axi_rdata_r <= 32'h00000000;
                  s_axi_rresp_r <= 2'h3;
               end
            endcase
         end
         if (s_axi_rvalid_r && s_axi_rready) begin
            s_axi_rvalid_r  <= 1'b0;
            s_axi_arready_r <= 1'b1;
         end
      end
   end

   // Widens a per-port mask to the two-bit mode fields
   function [2*NPORT-1:0] lock_bits;
      input [NPORT-1:0] m;
      integer j;
      begin
         lock_bits = {(2*NPORT){1'b0}};
         for (j = 0; j < NPORT; j = j + 1) begin
            lock_bits[2*j +: 2] = {m[j], m[j]};
         end
      end
   endfunction
endmodule

// ---- verif/mlat_table_asserts.sv ----
// Port checker for the address table.
// Bound into every mlat_table instance.
`timescale 1ns/1ps
module mlat_table_asserts #(parameter NPORT = 10, parameter DEPTH = 16) (
   // Clock, reset and frame side
   input wire             clock, reset, req_valid, req_ready_r, rsp_valid_r, rsp_drop_r,
   input wire [NPORT-1:0] rsp_ports_r,
   // Register bus
   input wire             s_axi_awready_r, s_axi_wready_r, s_axi_bvalid_r, s_axi_bready,
   input wire             s_axi_arvalid, s_axi_arready_r, s_axi_rvalid_r, s_axi_rready,
   input wire [31:0]      s_axi_rdata_r
);
   int wait_c;
   default clocking @(posedge clock);
   endclocking
   default disable iff (reset);
   // Cycles since the last query was taken
   always @(posedge clock or posedge reset)
      if (reset) wait_c <= 0;
      else if (req_valid && req_ready_r) wait_c <= 1;
      else if (wait_c != 0) wait_c <= wait_c + 1;
   a_rsp_latency: assert property (rsp_valid_r |-> wait_c == DEPTH + 2)
      else $error("decision latency wrong");
   a_rsp_pulse: assert property (rsp_valid_r |=> !rsp_valid_r)
      else $error("decision longer than one cycle");
   a_query_busy: assert property (req_valid && req_ready_r |=> !req_ready_r [*8])
      else $error("ready during scan");
   a_drop_ports: assert property (rsp_valid_r && rsp_drop_r |-> rsp_ports_r == '0)
      else $error("dropped frame has ports");
   a_bvalid_hold: assert property (s_axi_bvalid_r && !s_axi_bready |=> s_axi_bvalid_r)
      else $error("write response lost");
   a_write_block: assert property (s_axi_bvalid_r |-> !s_axi_awready_r && !s_axi_wready_r)
      else $error("write taken during response");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready_r |=> s_axi_rvalid_r)
      else $error("read answer late");
   a_rdata_hold: assert property (s_axi_rvalid_r && !s_axi_rready |=> $stable(s_axi_rdata_r))
      else $error("read data changed");
endmodule
bind mlat_table mlat_table_asserts #(.NPORT(NPORT), .DEPTH(DEPTH)) mlat_table_asserts_inst (.*);

// ---- verif/mlat_pipe_model.sv ----
// Forwarding pipeline model: one frame query per go pulse.
// Assumes go is raised for one cycle while no query is pending.
`timescale 1ns/1ps
module mlat_pipe_model (
   // Bench side
   input wire         clock, go, req_ready_r,
   input wire [47:0]  da, sa,
   input wire [3:0]   pt,
   // Query towards the table
   output logic       req_valid = 1'b0,
   output logic [47:0] destination_hw_address = 48'h0, source_hw_address = 48'h0,
   output logic [3:0] req_port = 4'h0
);
   // Hold the query until taken, then scramble the released addresses
   always @(posedge clock)
      if (req_valid && req_ready_r) begin
         req_valid <= 1'b0;
         destination_hw_address <= ~destination_hw_address;
         source_hw_address <= ~source_hw_address;
      end else if (go) begin
         req_valid <= 1'b1;
         destination_hw_address <= da;
         source_hw_address <= sa;
         req_port <= pt;
      end
endmodule

// ---- verif/mlat_table_test.sv ----
// Self-checking bench for the address table.
// Assumes DEPTH 16 and a 20-cycle second.
`timescale 1ns/1ps
module mlat_table_test;
   logic clock = 1'b0, reset = 1'b1, go = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, req_valid, req_ready_r;
   logic rsp_valid_r, rsp_drop_r, rsp_hit_r, s_axi_awready_r, s_axi_wready_r, s_axi_bvalid_r;
   logic s_axi_arready_r, s_axi_rvalid_r;
   logic [1:0] s_axi_bresp_r, s_axi_rresp_r, rr;
   logic [3:0] pt = 4'h0, req_port, s_axi_wstrb = 4'hF;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [9:0] rsp_ports_r, lock_mask = 10'h000;
   logic [11:0] req_vid = 12'h001;
   logic [19:0] lock_mode = 20'h01000;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata_r, rv;
   logic [47:0] da = 48'h0, sa = 48'h0, destination_hw_address, source_hw_address;
   int miscompares = 0, samples_checked = 0, cyc = 0;
   mlat_table #(.DEPTH(16), .CLK_HZ(20)) mlat_table_inst (.*);
   mlat_pipe_model mlat_pipe_model_inst (.*);
   always #5 clock = ~clock;
   task close_out;
      $display("checked %0d mismatched %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         miscompares++;
         close_out();
      end
   end
   task chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do @(posedge clock); while (!(s_axi_awready_r && s_axi_wready_r));
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      do @(posedge clock); while (!s_axi_bvalid_r);
      s_axi_bready <= 1'b0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clock); while (!s_axi_arready_r);
      s_axi_arvalid <= 1'b0;
      do @(posedge clock); while (!s_axi_rvalid_r);
      rv = s_axi_rdata_r;
      rr = s_axi_rresp_r;
      s_axi_rready <= 1'b0;
   endtask
   task cmd(input logic [31:0] c);
      wr(8'h1C, c);
      do rd(8'h20); while (rv[0]);
   endtask
   task q(input logic [3:0] p, input logic [47:0] d, input logic [47:0] s);
      @(posedge clock);
      pt <= p;
      da <= d;
      sa <= s;
      go <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
      do @(posedge clock); while (!rsp_valid_r);
   endtask
   task t_regs;
      rd(8'h00);
      chk(rv, 32'h1);
      rd(8'h04);
      chk(rv, 32'h12C);
      wr(8'h04, 32'h5);
      rd(8'h04);
      chk(rv, 32'hA);
      rd(8'h40);
      chk(rr, 32'h3);
   endtask
   task t_fwd;
      wr(8'h0C, 32'h1);
      wr(8'h10, 32'hAA);
      wr(8'h18, 32'h6);
      cmd(32'h1);
      q(4'h0, 48'hAA, 48'h11);
      chk({rsp_hit_r, rsp_ports_r}, 32'h406);
      q(4'h3, 48'hBB, 48'h22);
      chk({rsp_hit_r, rsp_ports_r}, 32'h3F7);
      q(4'h0, 48'h22, 48'h11);
      chk({rsp_hit_r, rsp_ports_r}, 32'h408);
   endtask
   task t_secure;
      lock_mask <= 10'h040;
      wr(8'h08, 32'h2800);
      rd(8'h08);
      chk(rv, 32'h1800);
      q(4'h6, 48'hBB, 48'h33);
      chk({rsp_drop_r, rsp_ports_r}, 32'h3BF);
      q(4'h5, 48'h22, 48'h33);
      chk({rsp_drop_r, rsp_ports_r}, 32'h400);
      q(4'h5, 48'h22, 48'hAA);
      chk({rsp_drop_r, rsp_ports_r}, 32'h008);
   endtask
   task t_age;
      repeat (450) @(posedge clock);
      q(4'h0, 48'h22, 48'h11);
      chk({rsp_hit_r, rsp_ports_r}, 32'h3FE);
      q(4'h3, 48'hAA, 48'h44);
      chk(rsp_hit_r, 32'h1);
   endtask
   task t_flush;
      wr(8'h00, 32'h0);
      repeat (450) @(posedge clock);
      q(4'h0, 48'h44, 48'h11);
      chk(rsp_hit_r, 32'h1);
      cmd(32'h4);
      q(4'h0, 48'h44, 48'h11);
      chk(rsp_hit_r, 32'h0);
      cmd(32'h3);
      chk(rv[2:1], 32'h2);
      rd(8'h28);
      chk(rv, 32'hAA);
   endtask
   initial begin
      repeat (16) @(posedge clock);
      reset <= 1'b0;
      t_regs();
      t_fwd();
      t_secure();
      t_age();
      t_flush();
      close_out();
   end
endmodule
